// *** aiit_defs.vh ***
// constants for the adc injection interval timer
`ifndef AIIT_DEFS_VH
`define AIIT_DEFS_VH
`define AIIT_ADDR_W        4
`define AIIT_OFF_CTRL      4'h0
`define AIIT_OFF_START     4'h1
`define AIIT_OFF_END       4'h2
`define AIIT_OFF_COUNT     4'h3
`define AIIT_OFF_ENABLE    4'h4
`define AIIT_BIT_RUN       0
`define AIIT_BIT_DIR       1
`define AIIT_BIT_CONT      2
`define AIIT_BIT_RELOAD    3
`define AIIT_BIT_OE        4
`define AIIT_PRE_LSB       8
`define AIIT_PRE_W         4
`define AIIT_BIT_PERIPH    0
`define AIIT_BIT_SEL10     10
`define AIIT_CTRL_RST      16'h0000
`define AIIT_CTRL_MASK     16'h0F1F
`define AIIT_ENA_MASK      16'h0401
`define AIIT_VAL_RST       16'h0000
`define AIIT_PRE_BASE      2
`define AIIT_PULSE_CYC     12
`endif

// *** aiit_prescaler.v ***
// exponential prescaler producing a one-cycle counting enable
`timescale 1ns/10ps
module aiit_prescaler #(
    parameter CNT_W = 34
) (
    clk,
    rst,
    run,
    expSel,
    tick
);
    input  wire       clk;
    input  wire       rst;
    input  wire       run;
    input  wire [3:0] expSel;
    output wire       tick;

    reg  [CNT_W-1:0] div_r;
    wire [CNT_W-1:0] divMask;
    wire [5:0]       shiftAmt;

    // period is 2^(expSel+2): four cycles to 2^17 at expSel 15; no exponent above 17 is reachable
    assign shiftAmt = {2'h0, expSel} + 6'h02; // RQ2 RQ14
    assign divMask  = ({{(CNT_W-1){1'b0}}, 1'b1} << shiftAmt) - {{(CNT_W-1){1'b0}}, 1'b1};
    assign tick     = run && ((div_r & divMask) == divMask); // RQ14

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= {CNT_W{1'b0}};
        end else if (!run) begin
            div_r <= {CNT_W{1'b0}};
        end else begin
            div_r <= div_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// *** aiit_timer.v ***
// adc injection interval timer: up/down counter, compare, trigger pulse
// Overview of operation
// (RQ1) 16-bit up/down counter clocked through a 4-bit exponential prescaler.
// (RQ2) counting period spans four CPU cycles up to two to the 33 cycles; the 4-bit prescaler here reaches 2^17 at most.
// (RQ3) on start, count loads from start value at first counting enable.
// (RQ4) before match, direction 0 decrements, direction 1 increments per tick.
// (RQ5) count compared against end value every tick; equality ends period.
// (RQ6) on match: select 0 stops, select 1 continues, with reload reloads start.
// (RQ7) start loaded but held if start lies beyond end in counting direction.
// (RQ8) trigger only on match with output enable; otherwise pin high impedance.
// (RQ9) each trigger is one positive pulse of exactly 12 CPU cycles; here a match in the last high cycle starts the next pulse with no gap.
// (RQ10) run bit low holds count; clearing it stops the timer.
// (RQ11) software changes configuration only while stopped.
// (RQ12) software writes control first with run clear, then with run set.
// (RQ13) timer works only with peripheral enable and select bit 10 both set.
// (RQ14) prescaler gives a one-cycle enable at power-of-two divisions.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "aiit_defs.vh"
module aiit_timer #(
    parameter PULSE_CYC = `AIIT_PULSE_CYC
) (
    clk,
    rst,
    regAddr,
    regWrData,
    regWrStb,
    regRdStb,
    regRdData,
    injTrigOut,
    injTrigOutEnN
);
    input  wire                    clk;
    input  wire                    rst;
    input  wire [`AIIT_ADDR_W-1:0] regAddr;
    input  wire [15:0]             regWrData;
    input  wire                    regWrStb;
    input  wire                    regRdStb;
    output reg  [15:0]             regRdData;
    output reg                     injTrigOut;
    output reg                     injTrigOutEnN;

    reg  [15:0] ctrl_r;
    reg  [15:0] start_r;
    reg  [15:0] end_r;
    reg  [15:0] count_r;
    reg  [15:0] count_nxt;
    reg  [15:0] enable_r;
    reg         loaded_r;
    reg         hold_r;
    reg         stopped_r;
    reg  [3:0]  pulse_r;
    reg         loaded_nxt;
    reg         hold_nxt;
    reg         stopped_nxt;
    reg         match;
    wire        runBit;
    wire        dirUp;
    wire        contSel;
    wire        reloadEn;
    wire        outEn;
    wire        active;
    wire        tick;
    wire [3:0]  pulseLen;

    assign runBit   = ctrl_r[`AIIT_BIT_RUN];
    assign dirUp    = ctrl_r[`AIIT_BIT_DIR];
    assign contSel  = ctrl_r[`AIIT_BIT_CONT];
    assign reloadEn = ctrl_r[`AIIT_BIT_RELOAD];
    assign outEn    = ctrl_r[`AIIT_BIT_OE];
    assign pulseLen = PULSE_CYC[3:0];
    // both enables gate the prescaler and the counter
    assign active   = runBit && enable_r[`AIIT_BIT_PERIPH] && enable_r[`AIIT_BIT_SEL10]; // RQ13

    aiit_prescaler #(
        .CNT_W (34)
    ) u_pre (
        .clk    (clk),
        .rst    (rst),
        .run    (active),
        .expSel (ctrl_r[`AIIT_PRE_LSB +: `AIIT_PRE_W]),
        .tick   (tick)
    ); // RQ1

    // configuration writes while running are accepted as is; software keeps it safe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= `AIIT_CTRL_RST;
            start_r  <= `AIIT_VAL_RST;
            end_r    <= `AIIT_VAL_RST;
            enable_r <= `AIIT_CTRL_RST;
        end else if (regWrStb) begin
            case (regAddr)
                `AIIT_OFF_CTRL: begin
                    ctrl_r <= regWrData & `AIIT_CTRL_MASK;
                end
                `AIIT_OFF_START: begin
                    start_r <= regWrData;
                end
                `AIIT_OFF_END: begin
                    end_r <= regWrData;
                end
                `AIIT_OFF_ENABLE: begin
                    enable_r <= regWrData & `AIIT_ENA_MASK;
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRdStb) begin
            case (regAddr)
                `AIIT_OFF_CTRL: begin
                    regRdData <= ctrl_r;
                end
                `AIIT_OFF_START: begin
                    regRdData <= start_r;
                end
                `AIIT_OFF_END: begin
                    regRdData <= end_r;
                end
                `AIIT_OFF_COUNT: begin
                    regRdData <= count_r;
                end
                `AIIT_OFF_ENABLE: begin
                    regRdData <= enable_r;
                end
                default: begin
                    regRdData <= 16'h0000;
                end
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    always @* begin
        count_nxt   = count_r;
        loaded_nxt  = loaded_r;
        hold_nxt    = hold_r;
        stopped_nxt = stopped_r;
        match       = 1'b0;
        if (!active) begin
            loaded_nxt  = 1'b0; // RQ10
            stopped_nxt = 1'b0;
        end else if (tick) begin
            if (!loaded_r) begin
                count_nxt  = start_r; // RQ3
                loaded_nxt = 1'b1;
                hold_nxt   = dirUp ? (start_r > end_r) : (start_r < end_r); // RQ7
            end else if (!hold_r && !stopped_r) begin
                match = (count_r == end_r); // RQ5
                if (match && !contSel) begin
                    stopped_nxt = 1'b1; // RQ6
                end else if (match && reloadEn) begin
                    count_nxt = start_r; // RQ6
                end else if (dirUp) begin
                    count_nxt = count_r + 16'h0001; // RQ4
                end else begin
                    count_nxt = count_r - 16'h0001; // RQ4
                end
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r   <= `AIIT_VAL_RST;
            loaded_r  <= 1'b0;
            hold_r    <= 1'b0;
            stopped_r <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            loaded_r  <= loaded_nxt;
            hold_r    <= hold_nxt;
            stopped_r <= stopped_nxt;
        end
    end

    // a match before the last high cycle of a pulse restarts nothing; one in that cycle adds a new 12-cycle pulse with no gap
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_r       <= 4'h0;
            injTrigOut    <= 1'b0;
            injTrigOutEnN <= 1'b1;
        end else begin
            injTrigOutEnN <= ~outEn; // RQ8
            if (match && outEn && pulse_r == 4'h0) begin
                pulse_r    <= pulseLen - 4'h1; // RQ9
                injTrigOut <= 1'b1; // RQ8
            end else if (pulse_r != 4'h0) begin
                pulse_r    <= pulse_r - 4'h1;
                injTrigOut <= 1'b1; // RQ9
            end else begin
                injTrigOut <= 1'b0;
            end
        end
    end
endmodule

// *** aiit_timer_props.sv ***
// port checker for the injection interval timer
`timescale 1ns/10ps
`include "aiit_defs.vh"
module aiit_timer_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic        injTrigOut,
    input wire logic        injTrigOutEnN
);
    logic [15:0] ctl_r, sta_r, ena_r;
    // shadow copies let the read and enable checks work without the body
    wire         act = ctl_r[0] & ena_r[0] & ena_r[10];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= 16'h0000;
            sta_r <= 16'h0000;
            ena_r <= 16'h0000;
        end else if (regWrStb) begin
            if (regAddr == 4'h0) ctl_r <= regWrData;
            if (regAddr == 4'h1) sta_r <= regWrData;
            if (regAddr == 4'h4) ena_r <= regWrData;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence pulseHigh;
        injTrigOut[*8] ##1 injTrigOut[*4];
    endsequence
    chk_rd_idle: assert property (!$past(regRdStb) |-> regRdData == 16'h0000)
        else $error("read data not zero outside read");
    chk_rd_ctrl: assert property (regRdStb && regAddr == 4'h0 |=> regRdData == $past(ctl_r & 16'h0F1F))
        else $error("control readback wrong");
    chk_rd_start: assert property (regRdStb && regAddr == 4'h1 |=> regRdData == $past(sta_r))
        else $error("start readback wrong");
    chk_rd_enable: assert property (regRdStb && regAddr == 4'h4 |=> regRdData == $past(ena_r & 16'h0401))
        else $error("enable readback wrong");
    chk_rd_unmapped: assert property (regRdStb && regAddr > 4'h4 |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    chk_pulse_width: assert property ($rose(injTrigOut) |-> pulseHigh ##1 !injTrigOut)
        else $error("trigger pulse width wrong");
    chk_pulse_driven: assert property (injTrigOut |-> !injTrigOutEnN)
        else $error("trigger high on released pin");
    chk_pulse_active: assert property ($rose(injTrigOut) |-> $past(act))
        else $error("trigger while timer inactive");
    chk_oe_release: assert property (regWrStb && regAddr == 4'h0 && !regWrData[4] |-> ##[1:2] injTrigOutEnN)
        else $error("pin not released");
endmodule

// *** aiit_cap_model.sv ***
// capture input model: counts trigger events seen on the injection pin
`timescale 1ns/10ps
module aiit_cap_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic trig,
    input wire logic trigEnN,
    output int       events,
    output int       gap,
    output int       width
);
    // released pin floats; z never counts as an edge
    wire  pin = trigEnN ? 1'bz : trig;
    logic prev_r;
    int   since_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            events <= 0;
            since_r <= 0;
            prev_r <= 1'b0;
        end else begin
            prev_r <= (pin === 1'b1);
            since_r <= since_r + 1;
            if (pin === 1'b1 && !prev_r) begin
                events <= events + 1;
                gap <= since_r;
                since_r <= 1;
                width <= 1;
            end else if (pin === 1'b1) begin
                width <= width + 1;
            end
        end
    end
endmodule

// *** testbench.sv ***
// self-checking bench for the injection interval timer
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic        rdPend = 1'b0;
    logic [15:0] s;
    logic [15:0] expQ[$];
    wire  [15:0] regRdData;
    wire         injTrigOut, injTrigOutEnN;
    int          events, gap, width, b;
    int          n_errors = 0;
    int          total_checks = 0;
    always #4 clk = ~clk;
    aiit_timer i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .injTrigOut(injTrigOut), .injTrigOutEnN(injTrigOutEnN));
    aiit_cap_model i_cap (.clk(clk), .rst(rst), .trig(injTrigOut), .trigEnN(injTrigOutEnN),
        .events(events), .gap(gap), .width(width));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // read data stands one cycle only, so compare at the very next edge
    always @(posedge clk) begin
        rdPend <= regRdStb;
        if (rdPend) chk(regRdData, expQ.pop_front());
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        expQ.push_back(e);
        @(posedge clk);
        regRdStb <= 1'b0;
    endtask
    task automatic go(input logic [15:0] st, input logic [15:0] en, input logic [15:0] cfg);
        wr(4'h0, cfg);
        wr(4'h1, st);
        wr(4'h2, en);
        wr(4'h0, cfg | 16'h0001);
        repeat (60) @(posedge clk);
    endtask
    task automatic waitEv(input int n);
        b = events;
        for (int i = 0; i < 1000 && events < b + n; i++) @(posedge clk);
        chk(16'(events - b), 16'(n));
    endtask
    task give_verdict();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        give_verdict();
    end
    initial begin
        s = 16'($urandom(49)) & 16'h7FFF | 16'h0100;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
        go(s, s - 16'h0002, 16'h0010);
        rd(4'h3, 16'h0000);
        rd(4'h0, 16'h0011);
        wr(4'h4, 16'h0401);
        rd(4'h4, 16'h0401);
        b = events;
        go(s, s - 16'h0002, 16'h0010);
        chk(16'(events - b), 16'h0001);
        chk(16'(width), 16'h000C);
        rd(4'h3, s - 16'h0002);
        b = events;
        go(s, s + 16'h0003, 16'h0002);
        rd(4'h3, s + 16'h0003);
        chk(16'(events - b), 16'h0000);
        chk(16'(injTrigOutEnN), 16'h0001);
        go(s, s + 16'h0005, 16'h0000);
        rd(4'h3, s);
        go(s, s - 16'h0005, 16'h0002);
        rd(4'h3, s);
        // up, continue, reload, output on; the gap is four prescaler periods
        for (int e = 0; e < 3; e++) begin
            wr(4'h0, 16'h001E | 16'(e << 8));
            wr(4'h1, s);
            wr(4'h2, s + 16'h0003);
            wr(4'h0, 16'h001F | 16'(e << 8));
            waitEv(3);
            chk(16'(gap), 16'(16 << e));
        end
        wr(4'h0, 16'h021E);
        repeat (2) @(posedge clk);
        b = events;
        repeat (200) @(posedge clk);
        chk(16'(events - b), 16'h0000);
        give_verdict();
    end
endmodule
bind aiit_timer aiit_timer_props i_props (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .injTrigOut(injTrigOut), .injTrigOutEnN(injTrigOutEnN));
